// ### design/fdc_regs_pkg.sv
// constants and types for the floppy host register block
package fdc_regs_pkg;
  // register port offsets
  localparam logic [2:0] OFS_DOR = 3'h2;
  localparam logic [2:0] OFS_MSR = 3'h4;
  localparam logic [2:0] OFS_DATA = 3'h5;
  localparam logic [2:0] OFS_DIR = 3'h7;
  // drive output register fields
  localparam int DOR_RST_BIT = 2;
  localparam int DOR_DMA_BIT = 3;
  // data-rate-select and rate control fields
  localparam int DSR_SRST_BIT = 7;
  localparam int DSR_PRE_LSB = 2;
  localparam int CCR_SKIP_PRECOMP_BIT_BIT = 2;
  // rate codes and reset values
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_1M = 2'h3;
  localparam logic [7:0] DOR_RST_VAL = 8'h00;
  localparam logic [2:0] PRE_RST_VAL = 3'h0;
  localparam logic [3:0] THR_RST_VAL = 4'h0;
  // buffer geometry
  localparam int BUF_DEPTH = 16;
  localparam logic [4:0] BUF_FULL = 5'h10;
  localparam logic [4:0] BUF_ONE = 5'h01;
  // non-burst request gap
  localparam int CLK_PS = 4000;
  localparam int GAP_PS = 350000;
  localparam int GAP_CYC = (GAP_PS + CLK_PS - 1) / CLK_PS;
  localparam logic [6:0] GAP_LAST = 7'(GAP_CYC - 1);
  // main state and disk input register fixed bits
  localparam logic [3:0] MSR_LOW = 4'h0;
  localparam logic [3:0] DIR_PS2_ONES = 4'hf;
  localparam logic [2:0] DIR_M30_ZERO = 3'h0;
  // compatibility modes of the status and rate registers
  typedef enum logic [1:0] {
    CM_AT = 2'h0,
    CM_PS2 = 2'h1,
    CM_M30 = 2'h3
  } compat_t;
  // phase reported by the command sequencer
  typedef enum logic [1:0] {
    PH_CMD = 2'h0,
    PH_EXEC = 2'h1,
    PH_RES = 2'h3
  } phase_t;
  // request engine states
  typedef enum logic [1:0] {
    RQ_IDLE = 2'h0,
    RQ_ON = 2'h1,
    RQ_GAP = 2'h3
  } req_st_t;
  // settings carried by the configure command
  typedef struct packed {
    logic fifo_on;
    logic lock;
    logic [3:0] buffer_trigger_level;
  } cfg_cmd_t;
  // settings carried by the mode command
  typedef struct packed {
    logic burst;
    logic rd_dis;
    logic wr_dis;
  } mode_cmd_t;
endpackage

// ### design/floppy_host_data_rate_regs.sv
// host register block: data port with execution buffer, status and rate
`timescale 1ns/1ns
// Contract
// R1: host checks request and direction flags before each command byte
// R2: host checks request and direction flags before each result byte
// R3: buffer serves execution bytes only; command and result bytes bypass
// R4: buffer enable and trigger level come from the configure command
// R5: soft reset keeps buffer enabled when locked, else disables it
// R6: hardware reset disables buffer and zeroes trigger level
// R7: buffer serves dma, interrupt and polled execution transfers
// R8: burst mode holds request until the whole burst has moved
// R9: non-burst mode drops request 350 ns between transfers
// R10: mode command disables buffer separately for reads and writes
// R11: host services request within (level+1)*8 rate periods minus 16
// R12: disabled buffer acts as trigger level zero, request per byte
// R13: first mode drives only bit 7, change input active high
// R14: soft reset leaves the disk input status register alone
// R15: change bit is invalid while powered down
// R16: second mode reads ones in 6-3, rate in 2-1, change in 7
// R17: second mode bit 0 low for 1M/500k, high for 300k/250k
// R18: third mode: change low-active, zeros, dma gate, no-precomp, rate
// R19: rate control is write-only, soft-reset proof, resets to 250k
// R20: active rate follows the last rate write of either register
// R21: software writes zeros to unused rate control bits
// R22: third mode keeps no-precomp bit, shown in status bit 2
// R23: rate codes 11,00,01,10 give 1M,500k,300k,250k
// R24: direction flag 0 for host write, 1 for host read
// R25: configuration input selects one of three compatibility modes
module floppy_host_data_rate_regs
  import fdc_regs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic [7:0] rdata_oe_n,
  input wire compat_t compat_mode,
  input wire logic media_changed_input,
  input wire logic powered_down,
  input wire phase_t phase,
  input wire logic exec_to_host,
  input wire logic non_dma,
  input wire logic cfg_wr,
  input wire cfg_cmd_t cfg_cmd,
  input wire logic mode_wr,
  input wire mode_cmd_t mode_cmd,
  output logic [7:0] cmd_byte,
  output logic cmd_byte_valid,
  input wire logic [7:0] result_byte,
  input wire logic result_valid,
  output logic result_taken,
  input wire logic [7:0] disk_rd_byte,
  input wire logic disk_rd_valid,
  output logic [7:0] disk_wr_byte,
  output logic disk_wr_valid,
  input wire logic disk_wr_ready,
  output logic dma_req,
  output logic int_req,
  output logic overrun,
  output logic soft_reset,
  output logic [1:0] rate_sel,
  output logic [2:0] precomp_sel,
  output logic skip_precomp
);
  logic chg_meta_r, chg_r;
  logic [7:0] dor_r;
  logic [1:0] rate_r;
  logic [2:0] pre_r;
  logic skip_precomp_bit_r, srst_r;
  cfg_cmd_t cfg_r;
  mode_cmd_t mode_r;
  logic [7:0] mem_r [BUF_DEPTH];
  logic [3:0] wp_r, rp_r;
  logic [4:0] cnt_r;
  req_st_t req_r;
  logic [6:0] gap_r;
  logic req_out_r, dma_r, int_r;
  logic [7:0] rdata_r, oe_n_r, cmd_r, dwb_r;
  logic cmdv_r, taken_r, dwv_r, ovr_r;
  // decoded strobes and buffer bookkeeping
  logic wr_dor, wr_dsr, wr_ccr, wr_data, rd_data, exec, buf_on;
  logic [4:0] cap, thr1, space;
  logic [7:0] push_byte;
  logic push, pop, dense, soft_rst, host_xfer, want, drained, transfer_direction_flag, host_request_flag;

  // address decode of the plain register port
  assign wr_dor = wr & (addr == OFS_DOR);
  assign wr_dsr = wr & (addr == OFS_MSR);
  assign wr_ccr = wr & (addr == OFS_DIR);
  assign wr_data = wr & (addr == OFS_DATA);
  assign rd_data = rd & (addr == OFS_DATA);
  assign exec = (phase == PH_EXEC);
  // soft reset from the drive output level or the self-clearing rate bit
  assign soft_rst = ~dor_r[DOR_RST_BIT] | srst_r;

  // change input comes from a pin: two flops before use
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chg_meta_r <= 1'b0;
      chg_r <= 1'b0;
    end else begin
      chg_meta_r <= media_changed_input;
      chg_r <= chg_meta_r;
    end
  end

  // drive output register and the self-clearing soft reset bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dor_r <= DOR_RST_VAL;
      srst_r <= 1'b0;
    end else begin
      if (wr_dor) begin
        dor_r <= wdata;
      end
      srst_r <= wr_dsr & wdata[DSR_SRST_BIT];
    end
  end

  // rate state: only hardware reset touches it, soft reset is ignored
  // R19 rate hardware reset
  // R20 last write wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rate_r <= RATE_250K;
      pre_r <= PRE_RST_VAL;
      skip_precomp_bit_r <= 1'b0;
    end else if (wr_dsr) begin
      rate_r <= wdata[1:0];
      pre_r <= wdata[DSR_PRE_LSB +: 3];
    end else if (wr_ccr) begin
      // R21 upper bits ignored
      rate_r <= wdata[1:0];
      // R22 no-precomp kept in third mode
      if (compat_mode == CM_M30) begin
        skip_precomp_bit_r <= wdata[CCR_SKIP_PRECOMP_BIT_BIT];
      end
    end
  end

  // configure command settings
  // R4 set by configure only
  // R6 hardware reset defaults
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r.fifo_on <= 1'b0;
      cfg_r.lock <= 1'b0;
      cfg_r.buffer_trigger_level <= THR_RST_VAL;
    end else if (cfg_wr) begin
      cfg_r <= cfg_cmd;
    end else if (soft_rst && !cfg_r.lock) begin
      // R5 unlocked soft reset disables
      cfg_r.fifo_on <= 1'b0;
    end
  end

  // mode command settings
  // R10 per-direction disable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= '0;
    end else if (mode_wr) begin
      mode_r <= mode_cmd;
    end
  end

  // effective capacity and trigger level for the current direction
  // R10 direction gate
  // R12 disabled acts as level zero
  // R11 level sets host latency
  assign buf_on = cfg_r.fifo_on &
                  ~(exec_to_host ? mode_r.rd_dis : mode_r.wr_dis);
  assign cap = buf_on ? BUF_FULL : BUF_ONE;
  assign thr1 = buf_on ? (5'(cfg_r.buffer_trigger_level) + BUF_ONE) : BUF_ONE;
  assign space = cap - cnt_r;

  // buffer traffic, only ever during execution
  // R3 execution bytes only
  // R7 any host transfer style
  assign host_xfer = exec & (exec_to_host ? rd_data : wr_data);
  assign push = exec & (exec_to_host ? (disk_rd_valid && space != 5'h0)
                                     : (wr_data && space != 5'h0));
  assign push_byte = exec_to_host ? disk_rd_byte : wdata;
  assign pop = exec & (exec_to_host ? (rd_data && cnt_r != 5'h0)
                                    : (!dwv_r && cnt_r != 5'h0));

  // storage entries, written at the write pointer
  generate
    for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_ent
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          mem_r[i] <= 8'h00;
        end else if (push && wp_r == 4'(i)) begin
          mem_r[i] <= push_byte;
        end
      end
    end
  endgenerate

  // pointers and fill count; flushed outside execution and on soft reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_r <= 4'h0;
      rp_r <= 4'h0;
      cnt_r <= 5'h00;
    end else if (!exec || soft_rst) begin
      wp_r <= 4'h0;
      rp_r <= 4'h0;
      cnt_r <= 5'h00;
    end else begin
      if (push) begin
        wp_r <= wp_r + 4'h1;
      end
      if (pop) begin
        rp_r <= rp_r + 4'h1;
      end
      cnt_r <= cnt_r + 5'(push) - 5'(pop);
    end
  end

  // overrun: disk byte arrived with no room; held until phase ends or soft reset
  // the flag sets over a clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ovr_r <= 1'b0;
    end else if (exec && exec_to_host && disk_rd_valid &&
                 space == 5'h0) begin
      ovr_r <= 1'b1;
    end else if (!exec || soft_rst) begin
      ovr_r <= 1'b0;
    end
  end

  // byte toward the disk: held until the disk takes it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dwb_r <= 8'h00;
      dwv_r <= 1'b0;
    end else if (!exec || exec_to_host || soft_rst) begin
      dwv_r <= 1'b0;
    end else if (dwv_r) begin
      dwv_r <= ~disk_wr_ready;
    end else if (pop) begin
      dwb_r <= mem_r[rp_r];
      dwv_r <= 1'b1;
    end
  end

  // request raised at the trigger level, dropped when the burst is done
  assign want = exec_to_host ? (cnt_r >= thr1) : (space >= thr1);
  assign drained = exec_to_host ? (cnt_r == 5'h0) : (space == 5'h0);

  // request engine; the gap counter trades a few flops for exact timing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_r <= RQ_IDLE;
      gap_r <= 7'h00;
    end else if (!exec || soft_rst) begin
      req_r <= RQ_IDLE;
      gap_r <= 7'h00;
    end else begin
      unique case (req_r)
        RQ_IDLE: begin
          if (want) begin
            req_r <= RQ_ON;
          end
        end
        RQ_ON: begin
          // R9 drop between transfers
          if (!mode_r.burst && host_xfer) begin
            req_r <= RQ_GAP;
            gap_r <= 7'h00;
          // R8 burst holds to the end
          end else if (drained) begin
            req_r <= RQ_IDLE;
          end
        end
        RQ_GAP: begin
          if (gap_r == GAP_LAST) begin
            req_r <= RQ_IDLE;
          end else begin
            gap_r <= gap_r + 7'h01;
          end
        end
      endcase
    end
  end

  // route the request to the dma line or the interrupt line
  // R7 dma or interrupt request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_out_r <= 1'b0;
      dma_r <= 1'b0;
      int_r <= 1'b0;
    end else begin
      req_out_r <= (req_r == RQ_ON) & exec & ~soft_rst;
      dma_r <= (req_r == RQ_ON) & exec & ~soft_rst & ~non_dma &
               dor_r[DOR_DMA_BIT];
      int_r <= (req_r == RQ_ON) & exec & ~soft_rst & non_dma;
    end
  end

  // command bytes go straight to the sequencer, no buffering
  // R3 command bypass
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_r <= 8'h00;
      cmdv_r <= 1'b0;
      taken_r <= 1'b0;
    end else begin
      cmdv_r <= wr_data & (phase == PH_CMD);
      if (wr_data && phase == PH_CMD) begin
        cmd_r <= wdata;
      end
      // R3 result bypass
      taken_r <= rd_data & (phase == PH_RES) & result_valid;
    end
  end

  // status flags
  // R24 direction flag
  assign transfer_direction_flag = (phase == PH_RES) | (exec & exec_to_host);
  assign host_request_flag = (phase == PH_CMD) ? ~cmdv_r :
               (phase == PH_RES) ? result_valid :
               (non_dma ? req_out_r : 1'b0);
  // R17 density bit
  // R23 rate code meaning
  assign dense = (rate_r == RATE_300K) | (rate_r == RATE_250K);

  // read data, one cycle after the strobe; unmapped reads give zero
  // R25 mode picks the layout
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
      oe_n_r <= 8'hff;
    end else if (!rd) begin
      rdata_r <= 8'h00;
      oe_n_r <= 8'hff;
    end else begin
      oe_n_r <= 8'h00;
      unique case (addr)
        OFS_MSR: rdata_r <= {host_request_flag, transfer_direction_flag, exec & non_dma,
                             phase != PH_CMD, MSR_LOW};
        OFS_DATA: begin
          if (phase == PH_RES) begin
            rdata_r <= result_byte;
          end else if (exec && exec_to_host) begin
            rdata_r <= mem_r[rp_r];
          end else begin
            rdata_r <= 8'h00;
          end
        end
        // R14 no soft reset state here
        // R15 change bit not valid asleep
        OFS_DIR: begin
          unique case (compat_mode)
            CM_AT: begin
              // R13 only bit 7 driven
              rdata_r <= {chg_r & ~powered_down, 7'h00};
              oe_n_r <= 8'h7f;
            end
            // R16 second mode layout
            CM_PS2: rdata_r <= {chg_r & ~powered_down, DIR_PS2_ONES,
                                rate_r, dense};
            // R18 third mode layout
            default: rdata_r <= {~chg_r & ~powered_down, DIR_M30_ZERO,
                                 dor_r[DOR_DMA_BIT], skip_precomp_bit_r, rate_r};
          endcase
        end
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  // all outputs straight from flops
  assign rdata = rdata_r;
  assign rdata_oe_n = oe_n_r;
  assign cmd_byte = cmd_r;
  assign cmd_byte_valid = cmdv_r;
  assign result_taken = taken_r;
  assign disk_wr_byte = dwb_r;
  assign disk_wr_valid = dwv_r;
  assign dma_req = dma_r;
  assign int_req = int_r;
  assign overrun = ovr_r;
  assign soft_reset = srst_r;
  assign rate_sel = rate_r;
  assign precomp_sel = pre_r;
  assign skip_precomp = skip_precomp_bit_r;
endmodule // floppy_host_data_rate_regs

// ### bench/fdc_regs_assertions.sv
// port checker for the floppy host register block
`timescale 1ns/1ns
module fdc_regs_checker
  import fdc_regs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] rdata_oe_n,
  input wire compat_t compat_mode,
  input wire logic powered_down,
  input wire phase_t phase,
  input wire logic non_dma,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_byte_valid,
  input wire logic dma_req,
  input wire logic [1:0] rate_sel,
  input wire logic skip_precomp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // either rate register is written at this edge
  wire rate_wr = wr && (addr == OFS_DIR || addr == OFS_MSR);
  // status read in one layout; the answer stands one cycle later
  sequence s_dir_rd(compat_t m);
    rd && addr == OFS_DIR && compat_mode == m;
  endsequence
  a_at_oe_mask: assert property (
    s_dir_rd(CM_AT) |=> rdata_oe_n == 8'h7f)
    else $error("first layout drives extra bits");
  a_ps2_layout: assert property (
    s_dir_rd(CM_PS2) |=> rdata[6:3] == DIR_PS2_ONES
      && rdata[2:1] == $past(rate_sel))
    else $error("second layout bits wrong");
  a_dense_bit: assert property (
    s_dir_rd(CM_PS2) |=> rdata[0] == $past(rate_sel[1] ^ rate_sel[0]))
    else $error("density bit wrong");
  a_m30_layout: assert property (
    s_dir_rd(CM_M30) |=> rdata[6:4] == DIR_M30_ZERO
      && rdata[2:0] == $past({skip_precomp, rate_sel}))
    else $error("third layout bits wrong");
  a_power_mask: assert property (
    s_dir_rd(CM_PS2) ##0 powered_down |=> !rdata[7])
    else $error("change bit shown while powered down");
  a_rate_follow: assert property (
    rate_wr |=> rate_sel == $past(wdata[1:0]))
    else $error("rate not taken from last write");
  a_rate_hold: assert property (
    !rate_wr |=> $stable(rate_sel))
    else $error("rate changed without a write");
  a_nondma_req: assert property (
    non_dma [*2] |-> !dma_req)
    else $error("dma request in non-dma transfer");
  a_cmd_bypass: assert property (
    wr && addr == OFS_DATA && phase == PH_CMD
      |=> cmd_byte_valid && cmd_byte == $past(wdata))
    else $error("command byte not passed straight on");
endmodule // fdc_regs_checker

bind floppy_host_data_rate_regs fdc_regs_checker fdc_regs_checker_i (
  .clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .rdata_oe_n,
  .compat_mode, .powered_down, .phase, .non_dma, .cmd_byte,
  .cmd_byte_valid, .dma_req, .rate_sel, .skip_precomp);

// ### bench/host_bus_model.sv
// host processor and dma responder on the register port
`timescale 1ns/1ns
module host_bus_model
  import fdc_regs_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic dma_req,
  input wire logic int_req,
  output logic [2:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  int stalls;  // bounded waits that ran out
  initial begin
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    stalls = 0;
  end
  // callers keep unused rate bits zero; released data is inverted
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_rqm(input logic dir);
    logic [7:0] s;
    s = 8'h00;
    for (int n = 0; n < 50 && !(s[7] && s[6] == dir); n++) begin
      rd_reg(OFS_MSR, s);
    end
    if (!(s[7] && s[6] == dir))
      stalls++;
  endtask
  task automatic serve(output logic [7:0] d);
    for (int n = 0; n < 300 && !(dma_req || int_req); n++) begin
      @(posedge clk);
    end
    if (!(dma_req || int_req))
      stalls++;
    rd_reg(OFS_DATA, d);
  endtask
endmodule // host_bus_model

// ### bench/floppy_host_data_rate_regs_tb.sv
// self-checking bench for the floppy host register block
`timescale 1ns/1ns
module floppy_host_data_rate_regs_tb;
  import fdc_regs_pkg::*;
  logic clk, arst_n, wr, rd, media_changed_input, powered_down;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, rdata_oe_n, cmd_byte, result_byte;
  logic [7:0] disk_rd_byte, disk_wr_byte;
  compat_t compat_mode;
  phase_t phase;
  cfg_cmd_t cfg_cmd;
  mode_cmd_t mode_cmd;
  logic exec_to_host, non_dma, cfg_wr, mode_wr, cmd_byte_valid;
  logic result_valid, result_taken, disk_rd_valid, disk_wr_valid;
  logic disk_wr_ready, dma_req, int_req, overrun, soft_reset, skip_precomp;
  logic [1:0] rate_sel;
  logic [2:0] precomp_sel;
  int err_count = 0;
  int comparisons = 0;
  floppy_host_data_rate_regs floppy_host_data_rate_regs_i (.clk, .arst_n,
    .addr, .wdata, .wr, .rd, .rdata, .rdata_oe_n, .compat_mode,
    .media_changed_input, .powered_down, .phase, .exec_to_host, .non_dma,
    .cfg_wr, .cfg_cmd, .mode_wr, .mode_cmd, .cmd_byte, .cmd_byte_valid,
    .result_byte, .result_valid, .result_taken, .disk_rd_byte,
    .disk_rd_valid, .disk_wr_byte, .disk_wr_valid, .disk_wr_ready,
    .dma_req, .int_req, .overrun, .soft_reset, .rate_sel, .precomp_sel,
    .skip_precomp);
  host_bus_model host_bus_model_i (.clk, .rdata, .dma_req, .int_req,
    .addr, .wdata, .wr, .rd);
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    err_count += host_bus_model_i.stalls;
    $display("mismatches=%0d compares=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one byte from the disk side into the execution path
  task automatic push(input logic [7:0] b);
    @(posedge clk);
    disk_rd_byte <= b;
    disk_rd_valid <= 1'b1;
    @(posedge clk);
    disk_rd_valid <= 1'b0;
  endtask
  task automatic set_cfg(input logic [3:0] t, input logic burst);
    @(posedge clk);
    cfg_cmd <= '{1'b1, 1'b0, t};
    mode_cmd <= '{burst, 1'b0, 1'b0};
    cfg_wr <= 1'b1;
    mode_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    mode_wr <= 1'b0;
  endtask
  // a hang is cut short here
  initial begin
    #400000;
    err_count++;
    end_sim();
  end
  initial begin
    logic [7:0] d;
    int n;
    {arst_n, media_changed_input, powered_down, exec_to_host} = 4'h0;
    {non_dma, cfg_wr, mode_wr, result_valid, disk_rd_valid} = 5'h0;
    {result_byte, disk_rd_byte, cfg_cmd, mode_cmd} = '0;
    compat_mode = CM_M30;
    phase = PH_CMD;
    disk_wr_ready = 1'b1;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk({6'h0, rate_sel}, {6'h0, RATE_250K});
    host_bus_model_i.rd_reg(OFS_DIR, d);
    chk(d, 8'h82);
    host_bus_model_i.wr_reg(OFS_DOR, 8'h0c);
    host_bus_model_i.wr_reg(OFS_DIR, 8'h07);
    host_bus_model_i.rd_reg(OFS_DIR, d);
    chk(d, 8'h8f);
    // soft reset through the rate select write keeps no-precomp
    host_bus_model_i.wr_reg(OFS_MSR, 8'h8d);
    #1 chk({7'h0, soft_reset}, 8'h01);
    chk({5'h0, precomp_sel}, 8'h03);
    host_bus_model_i.rd_reg(OFS_DIR, d);
    chk(d, 8'h8d);
    compat_mode <= CM_PS2;
    media_changed_input <= 1'b1;
    repeat (3) @(posedge clk);
    for (int c = 0; c < 4; c++) begin
      host_bus_model_i.wr_reg(OFS_DIR, 8'(c));
      host_bus_model_i.rd_reg(OFS_DIR, d);
      chk(d, {5'h1f, 2'(c), c[1] ^ c[0]});
    end
    powered_down <= 1'b1;
    host_bus_model_i.rd_reg(OFS_DIR, d);
    chk(d, 8'h7e);
    powered_down <= 1'b0;
    compat_mode <= CM_AT;
    host_bus_model_i.rd_reg(OFS_DIR, d);
    chk({d[7], 7'h0}, 8'h80);
    chk(rdata_oe_n, 8'h7f);
    // command byte then result byte, both outside the buffer
    host_bus_model_i.wait_rqm(1'b0);
    host_bus_model_i.wr_reg(OFS_DATA, 8'h13);
    #1 chk(cmd_byte, 8'h13);
    phase <= PH_RES;
    result_byte <= 8'hc5;
    result_valid <= 1'b1;
    host_bus_model_i.wait_rqm(1'b1);
    host_bus_model_i.rd_reg(OFS_DATA, d);
    chk(d, 8'hc5);
    chk({7'h0, result_taken}, 8'h01);
    result_valid <= 1'b0;
    phase <= PH_EXEC;
    exec_to_host <= 1'b1;
    // disabled buffer asks once per byte, dma then interrupt
    push(8'h5a);
    host_bus_model_i.serve(d);
    chk(d, 8'h5a);
    chk({6'h0, int_req, dma_req}, 8'h01);
    non_dma <= 1'b1;
    push(8'h66);
    host_bus_model_i.serve(d);
    chk(d, 8'h66);
    chk({6'h0, int_req, dma_req}, 8'h02);
    non_dma <= 1'b0;
    // non-burst gap after a serviced byte
    set_cfg(4'h0, 1'b0);
    push(8'ha0);
    push(8'ha1);
    host_bus_model_i.serve(d);
    chk(d, 8'ha0);
    n = 0;
    repeat (150) begin
      @(posedge clk);
      n += int'(!dma_req);
    end
    chk({7'h0, n >= GAP_CYC && n < 150}, 8'h01);
    host_bus_model_i.serve(d);
    chk(d, 8'ha1);
    // let the gap run out, else the level test below could never fail
    repeat (100) @(posedge clk);
    // burst: no request below the level, then held until drained
    set_cfg(4'h2, 1'b1);
    push(8'hb0);
    push(8'hb1);
    repeat (4) @(posedge clk);
    chk({7'h0, dma_req}, 8'h00);
    push(8'hb2);
    for (int i = 0; i < 3; i++) begin
      host_bus_model_i.serve(d);
      chk(d, 8'hb0 + 8'(i));
      if (i < 2)
        chk({7'h0, dma_req}, 8'h01);
    end
    repeat (4) @(posedge clk);
    // write direction: the byte waits toward the disk until taken
    disk_wr_ready <= 1'b0;
    exec_to_host <= 1'b0;
    host_bus_model_i.wr_reg(OFS_DATA, 8'h3c);
    repeat (2) @(posedge clk);
    #1 chk(disk_wr_byte, 8'h3c);
    chk({6'h0, disk_wr_valid, dma_req}, 8'h03);
    // reads without the buffer hold one byte, so the second overruns
    @(posedge clk);
    mode_cmd <= '{1'b1, 1'b1, 1'b0};
    mode_wr <= 1'b1;
    exec_to_host <= 1'b1;
    @(posedge clk);
    mode_wr <= 1'b0;
    push(8'h11);
    #1 chk({7'h0, overrun}, 8'h00);
    push(8'h12);
    #1 chk({7'h0, overrun}, 8'h01);
    end_sim();
  end
endmodule // floppy_host_data_rate_regs_tb
